// ==== verilog/lpx_pkg.sv ====
// shared constants, types and legality function for the bank state tracker
package lpx_pkg;

  // ***************************************************
  // geometry and clock
  // ***************************************************
  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;
  localparam int CNT_W = 8;
  localparam int CLK_PERIOD_NS = 25;

  // ***************************************************
  // timing figures in ns, plain defaults
  // ***************************************************
  localparam int T_RP_NS = 18;
  localparam int T_RCD_NS = 18;
  localparam int T_RFCPB_NS = 60;
  localparam int T_RFCAB_NS = 130;
  localparam int T_MRR_NS = 10;
  localparam int T_MRW_NS = 250;
  localparam int T_XP_NS = 8;
  localparam int T_RRD_NS = 10;
  localparam int T_FAW_NS = 50;
  localparam int T_INIT_NS = 1000;
  localparam int T_BURST_NS = 100;

  // least times round up, never below one cycle
  function automatic int lpx_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [CNT_W-1:0] RP_CYC = CNT_W'(lpx_cyc(T_RP_NS));
  localparam logic [CNT_W-1:0] RCD_CYC = CNT_W'(lpx_cyc(T_RCD_NS));
  localparam logic [CNT_W-1:0] RFCPB_CYC = CNT_W'(lpx_cyc(T_RFCPB_NS));
  localparam logic [CNT_W-1:0] RFCAB_CYC = CNT_W'(lpx_cyc(T_RFCAB_NS));
  localparam logic [CNT_W-1:0] MRR_CYC = CNT_W'(lpx_cyc(T_MRR_NS));
  localparam logic [CNT_W-1:0] MRW_CYC = CNT_W'(lpx_cyc(T_MRW_NS));
  localparam logic [CNT_W-1:0] XP_CYC = CNT_W'(lpx_cyc(T_XP_NS));
  localparam logic [CNT_W-1:0] RRD_CYC = CNT_W'(lpx_cyc(T_RRD_NS));
  localparam logic [CNT_W-1:0] FAW_CYC = CNT_W'(lpx_cyc(T_FAW_NS));
  localparam logic [CNT_W-1:0] INIT_CYC = CNT_W'(lpx_cyc(T_INIT_NS));
  localparam logic [CNT_W-1:0] BURST_CYC = CNT_W'(lpx_cyc(T_BURST_NS));
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  // ***************************************************
  // commands and bank states
  // ***************************************************
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0, CMD_ACT = 4'h1, CMD_RD = 4'h2, CMD_WR = 4'h3,
    CMD_PRE = 4'h4, CMD_PREA = 4'h5, CMD_REFPB = 4'h6, CMD_REFAB = 4'h7,
    CMD_MRW = 4'h8, CMD_MRR = 4'h9, CMD_RST = 4'hA
  } lpx_cmd_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_ACTIVATING = 4'h1, ST_ACTIVE = 4'h3, ST_READING = 4'h2,
    ST_WRITING = 4'h6, ST_RD_AP = 4'h7, ST_WR_AP = 4'h5, ST_PRECHARGING = 4'h4,
    ST_REFRESHING = 4'hC, ST_MRR_IDLE = 4'hD, ST_MRR_ACT = 4'hF, ST_MRR_RST = 4'hE,
    ST_MRWRITING = 4'hA, ST_RESETTING = 4'hB, ST_POWER_ON = 4'h9, ST_PREALL = 4'h8
  } lpx_bank_e;

  localparam lpx_bank_e BANK_RST = ST_POWER_ON;
  localparam lpx_cmd_e CMD_RST_VAL = CMD_NOP;

  // commands that address the whole device rather than one bank
  function automatic logic lpx_is_wide(input lpx_cmd_e c);
    return c inside {CMD_PREA, CMD_REFAB, CMD_MRW, CMD_MRR, CMD_RST};
  endfunction

  // may command c meet a bank in state s
  function automatic logic lpx_cmd_ok(input lpx_cmd_e c, input lpx_bank_e s);
    case (c)
      CMD_ACT, CMD_REFPB, CMD_REFAB, CMD_MRW: return s == ST_IDLE;
      CMD_RD, CMD_WR: return s inside {ST_ACTIVE, ST_READING, ST_WRITING};
      CMD_PRE, CMD_PREA: return s inside {ST_IDLE, ST_ACTIVE, ST_READING, ST_WRITING};
      CMD_MRR: return s inside {ST_IDLE, ST_ACTIVE, ST_RESETTING, ST_ACTIVATING,
                                ST_PRECHARGING, ST_READING, ST_WRITING};
      CMD_RST: return s inside {ST_IDLE, ST_POWER_ON};
      default: return 1'b1;
    endcase
  endfunction

endpackage

// ==== verilog/lpx_cmd_if.sv ====
// command link between memory controller and bank state tracker
`timescale 1ns/1ps
interface lpx_cmd_if;
  import lpx_pkg::*;
  logic cke;
  lpx_cmd_e cmd;
  logic [BANK_W-1:0] bank;
  logic autoPre;
  lpx_bank_e [NUM_BANKS-1:0] bankState;

  modport dev (input cke, input cmd, input bank, input autoPre, output bankState);
  modport ctl (output cke, output cmd, output bank, output autoPre, input bankState);
endinterface

// ==== verilog/lpx_dram_ctl.sv ====
// controller end: issues only legal, timed commands from user requests
`timescale 1ns/1ps
module lpx_dram_ctl
  import lpx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  lpx_cmd_if.ctl link,
  input wire logic reqValid,
  input wire lpx_cmd_e reqCmd,
  input wire logic [BANK_W-1:0] reqBank,
  input wire logic reqAp,
  output logic reqReady,
  input wire logic lowPower
);

  // ***************************************************
  // state
  // ***************************************************
  lpx_cmd_e cmd_r, cmd_nxt;
  logic [BANK_W-1:0] bank_r, bank_nxt;
  logic ap_r, ap_nxt;
  logic cke_r, cke_nxt;
  logic ckePrev_r;
  logic [CNT_W-1:0] xpCnt_r, xpCnt_nxt;
  logic [CNT_W-1:0] rrdCnt_r, rrdCnt_nxt;
  logic [CNT_W-1:0] faw_r [4];
  logic [CNT_W-1:0] faw_nxt [4];
  logic [1:0] fawPtr_r, fawPtr_nxt;
  logic legal, allIdle, canIssue;
  lpx_bank_e tgt;

  assign link.cmd = cmd_r;
  assign link.bank = bank_r;
  assign link.autoPre = ap_r;
  assign link.cke = cke_r;
  assign reqReady = canIssue;

  // ***************************************************
  // next values
  // ***************************************************
  always_comb begin
    tgt = link.bankState[reqBank];
    allIdle = 1'b1;
    legal = 1'b1;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (link.bankState[b] != ST_IDLE) begin
        allIdle = 1'b0;
      end
      if (lpx_is_wide(reqCmd) && !lpx_cmd_ok(reqCmd, link.bankState[b])) begin
        legal = 1'b0;
      end
    end
    if (!lpx_is_wide(reqCmd) && !lpx_cmd_ok(reqCmd, tgt)) begin
      legal = 1'b0;
    end
    // no burst terminate: direction change waits for the burst to finish
    if ((reqCmd == CMD_RD && tgt == ST_WRITING) || (reqCmd == CMD_WR && tgt == ST_READING)) begin
      legal = 1'b0;
    end
    if (reqCmd == CMD_ACT && (rrdCnt_r != CNT_ZERO || faw_r[fawPtr_r] != CNT_ZERO)) begin
      legal = 1'b0;
    end
    // one idle cycle between commands so the tracker state is current
    canIssue = reqValid && reqCmd != CMD_NOP && legal && cke_r && ckePrev_r
               && xpCnt_r == CNT_ZERO && cmd_r == CMD_NOP;
    cmd_nxt = canIssue ? reqCmd : CMD_NOP;
    bank_nxt = canIssue ? reqBank : bank_r;
    ap_nxt = canIssue ? reqAp : 1'b0;
    rrdCnt_nxt = (rrdCnt_r != CNT_ZERO) ? rrdCnt_r - CNT_ONE : CNT_ZERO;
    fawPtr_nxt = fawPtr_r;
    for (int i = 0; i < 4; i++) begin
      faw_nxt[i] = (faw_r[i] != CNT_ZERO) ? faw_r[i] - CNT_ONE : CNT_ZERO;
    end
    if (canIssue && reqCmd == CMD_ACT) begin
      rrdCnt_nxt = RRD_CYC;
      faw_nxt[fawPtr_r] = FAW_CYC;
      fawPtr_nxt = fawPtr_r + 2'h1;
    end
    cke_nxt = cke_r;
    if (!lowPower) begin
      cke_nxt = 1'b1;
    end else if (allIdle && cmd_r == CMD_NOP && !canIssue) begin
      cke_nxt = 1'b0;
    end
    xpCnt_nxt = (xpCnt_r != CNT_ZERO) ? xpCnt_r - CNT_ONE : CNT_ZERO;
    if (cke_r && !ckePrev_r) begin
      xpCnt_nxt = XP_CYC;
    end
  end

  // ***************************************************
  // registers
  // ***************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_r <= CMD_RST_VAL;
      bank_r <= '0;
      ap_r <= 1'b0;
      cke_r <= 1'b1;
      // same as the device end, so no command lands inside its exit count
      ckePrev_r <= 1'b0;
      xpCnt_r <= CNT_ZERO;
      rrdCnt_r <= CNT_ZERO;
      fawPtr_r <= 2'h0;
      for (int i = 0; i < 4; i++) begin
        faw_r[i] <= CNT_ZERO;
      end
    end else begin
      cmd_r <= cmd_nxt;
      bank_r <= bank_nxt;
      ap_r <= ap_nxt;
      cke_r <= cke_nxt;
      ckePrev_r <= cke_r;
      xpCnt_r <= xpCnt_nxt;
      rrdCnt_r <= rrdCnt_nxt;
      fawPtr_r <= fawPtr_nxt;
      faw_r <= faw_nxt;
    end
  end

endmodule

// ==== verilog/lpx_dram_bank_dev.sv ====
// device end: per-bank state and timing tracker of the dram
`timescale 1ns/1ps
module lpx_dram_bank_dev
  import lpx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  lpx_cmd_if.dev link,
  output logic illegalCmd,
  output logic deviceReady
);

  // ***************************************************
  // state
  // ***************************************************
  lpx_bank_e [NUM_BANKS-1:0] state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r [NUM_BANKS];
  logic [CNT_W-1:0] cnt_nxt [NUM_BANKS];
  logic [CNT_W-1:0] initCnt_r, initCnt_nxt;
  logic [CNT_W-1:0] exitCnt_r, exitCnt_nxt;
  logic ckePrev_r;
  logic illegal_r, illegal_nxt;
  logic ready_r, ready_nxt;
  logic take, ok, hit;

  assign link.bankState = state_r;
  assign illegalCmd = illegal_r;
  assign deviceReady = ready_r;

  // state that a timed state falls back to when its counter expires
  function automatic lpx_bank_e lpx_after(input lpx_bank_e s);
    case (s)
      ST_ACTIVATING: return ST_ACTIVE;
      ST_READING, ST_WRITING: return ST_ACTIVE;
      ST_MRR_ACT: return ST_ACTIVE;
      ST_MRR_RST: return ST_RESETTING;
      ST_RD_AP, ST_WR_AP: return ST_IDLE;
      ST_PRECHARGING, ST_PREALL: return ST_IDLE;
      ST_REFRESHING: return ST_IDLE;
      ST_MRR_IDLE: return ST_IDLE;
      ST_MRWRITING: return ST_IDLE;
      default: return s;
    endcase
  endfunction

  // ***************************************************
  // next values
  // ***************************************************
  always_comb begin
    // commands count only with cke high on this and the last edge, past exit time
    take = link.cke && ckePrev_r && exitCnt_r == CNT_ZERO
           && link.cmd != CMD_NOP;
    ok = 1'b1;
    if (lpx_is_wide(link.cmd)) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (!lpx_cmd_ok(link.cmd, state_r[b])) begin
          ok = 1'b0;
        end
      end
    end else begin
      // other banks are never consulted here, so any bank may be busy
      ok = lpx_cmd_ok(link.cmd, state_r[link.bank]);
    end
    // undefined combinations are refused and flagged, state left alone
    illegal_nxt = take && !ok;
    exitCnt_nxt = (exitCnt_r != CNT_ZERO) ? exitCnt_r - CNT_ONE : CNT_ZERO;
    if (link.cke && !ckePrev_r) begin
      exitCnt_nxt = XP_CYC;
    end
    initCnt_nxt = (initCnt_r != CNT_ZERO) ? initCnt_r - CNT_ONE : CNT_ZERO;
    if (take && ok && link.cmd == CMD_RST) begin
      initCnt_nxt = INIT_CYC;
    end
    ready_nxt = 1'b1;
    for (int b = 0; b < NUM_BANKS; b++) begin
      state_nxt[b] = state_r[b];
      cnt_nxt[b] = cnt_r[b];
      if (cnt_r[b] != CNT_ZERO) begin
        cnt_nxt[b] = cnt_r[b] - CNT_ONE;
        if (cnt_r[b] == CNT_ONE) begin
          state_nxt[b] = lpx_after(state_r[b]);
        end
      end
      // resetting ends on the shared init counter, so a mode read inside it resumes
      // leave as the counter runs out; zero catches a bank back from a mode read
      if (state_r[b] == ST_RESETTING && initCnt_r inside {CNT_ZERO, CNT_ONE}) begin
        state_nxt[b] = ST_IDLE;
      end
      hit = take && ok && (lpx_is_wide(link.cmd) || link.bank == BANK_W'(b));
      if (hit) begin
        case (link.cmd)
          CMD_ACT: begin
            state_nxt[b] = ST_ACTIVATING;
            cnt_nxt[b] = RCD_CYC;
          end
          CMD_RD: begin
            state_nxt[b] = link.autoPre ? ST_RD_AP : ST_READING;
            cnt_nxt[b] = link.autoPre ? BURST_CYC + RP_CYC : BURST_CYC;
          end
          CMD_WR: begin
            state_nxt[b] = link.autoPre ? ST_WR_AP : ST_WRITING;
            cnt_nxt[b] = link.autoPre ? BURST_CYC + RP_CYC : BURST_CYC;
          end
          CMD_PRE: begin
            state_nxt[b] = ST_PRECHARGING;
            cnt_nxt[b] = RP_CYC;
          end
          CMD_PREA: begin
            state_nxt[b] = ST_PREALL;
            cnt_nxt[b] = RP_CYC;
          end
          CMD_REFPB: begin
            state_nxt[b] = ST_REFRESHING;
            cnt_nxt[b] = RFCPB_CYC;
          end
          CMD_REFAB: begin
            state_nxt[b] = ST_REFRESHING;
            cnt_nxt[b] = RFCAB_CYC;
          end
          CMD_MRW: begin
            state_nxt[b] = ST_MRWRITING;
            cnt_nxt[b] = MRW_CYC;
          end
          CMD_RST: begin
            state_nxt[b] = ST_RESETTING;
            cnt_nxt[b] = CNT_ZERO;
          end
          CMD_MRR: begin
            // banks in a timed transition keep counting through the read
            case (state_r[b])
              ST_IDLE: begin
                state_nxt[b] = ST_MRR_IDLE;
                cnt_nxt[b] = MRR_CYC;
              end
              ST_ACTIVE: begin
                state_nxt[b] = ST_MRR_ACT;
                cnt_nxt[b] = MRR_CYC;
              end
              ST_RESETTING: begin
                state_nxt[b] = ST_MRR_RST;
                cnt_nxt[b] = MRR_CYC;
              end
              default: begin
                state_nxt[b] = state_nxt[b];
              end
            endcase
          end
          default: begin
            state_nxt[b] = state_nxt[b];
          end
        endcase
      end
      if (state_nxt[b] inside {ST_POWER_ON, ST_RESETTING, ST_MRR_RST}) begin
        ready_nxt = 1'b0;
      end
    end
  end

  // ***************************************************
  // registers
  // ***************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        state_r[b] <= BANK_RST;
        cnt_r[b] <= CNT_ZERO;
      end
      initCnt_r <= CNT_ZERO;
      exitCnt_r <= CNT_ZERO;
      ckePrev_r <= 1'b0;
      illegal_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      initCnt_r <= initCnt_nxt;
      exitCnt_r <= exitCnt_nxt;
      ckePrev_r <= link.cke;
      illegal_r <= illegal_nxt;
      ready_r <= ready_nxt;
    end
  end

endmodule

// ==== dv/lpx_link_chk.sv ====
// concurrent checks on the command link between the two ends
`timescale 1ns/1ps
module lpx_link_chk
  import lpx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cke,
  input wire lpx_cmd_e cmd,
  input wire logic [BANK_W-1:0] bank,
  input wire logic autoPre,
  input wire lpx_bank_e [NUM_BANKS-1:0] bankState
);
  // ****
  // helpers
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  function automatic logic allIn(input lpx_bank_e [NUM_BANKS-1:0] v, input lpx_bank_e s);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < NUM_BANKS; k++) begin
      ok = ok && (v[k] == s);
    end
    return ok;
  endfunction

  // three high samples: enable stable on both edges and exit time spent
  sequence s_taken(lpx_cmd_e c);
    cmd == c && cke && $past(cke) && $past(cke, 2);
  endsequence

  // ****
  // per-bank timed states
  // ****
  for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
    chk_act_opens_row: assert property (
      s_taken(CMD_ACT) ##0 (bank == i && bankState[i] == ST_IDLE)
      |=> bankState[i] == ST_ACTIVATING ##1 bankState[i] == ST_ACTIVE)
      else $error("activate timing wrong");
    chk_pre_to_idle: assert property (
      s_taken(CMD_PRE) ##0 (bank == i && bankState[i] inside {ST_IDLE, ST_ACTIVE})
      |=> bankState[i] == ST_PRECHARGING ##1 bankState[i] == ST_IDLE)
      else $error("precharge timing wrong");
    chk_ap_burst_end: assert property (
      s_taken(CMD_WR) ##0 (bank == i && autoPre && bankState[i] == ST_ACTIVE)
      |=> (bankState[i] == ST_WR_AP)[*5] ##1 bankState[i] == ST_IDLE)
      else $error("auto precharge burst timing wrong");
    chk_bank_refresh: assert property (
      s_taken(CMD_REFPB) ##0 (bank == i && bankState[i] == ST_IDLE)
      |=> (bankState[i] == ST_REFRESHING)[*3] ##1 bankState[i] == ST_IDLE)
      else $error("bank refresh timing wrong");
  end

  // ****
  // device-wide states
  // ****
  chk_all_refresh: assert property (
    s_taken(CMD_REFAB) ##0 allIn(bankState, ST_IDLE)
    |=> allIn(bankState, ST_REFRESHING)[*6] ##1 allIn(bankState, ST_IDLE))
    else $error("all bank refresh timing wrong");
  chk_mode_write: assert property (
    s_taken(CMD_MRW) ##0 allIn(bankState, ST_IDLE)
    |=> allIn(bankState, ST_MRWRITING) ##9 allIn(bankState, ST_MRWRITING)
    ##1 allIn(bankState, ST_IDLE))
    else $error("mode write timing wrong");
  chk_mode_read: assert property (
    s_taken(CMD_MRR) ##0 allIn(bankState, ST_IDLE)
    |=> allIn(bankState, ST_MRR_IDLE) ##1 allIn(bankState, ST_IDLE))
    else $error("mode read return wrong");
  chk_reset_starts: assert property (
    s_taken(CMD_RST) ##0 allIn(bankState, ST_POWER_ON) |=> allIn(bankState, ST_RESETTING))
    else $error("reset command not taken");
endmodule

// ==== dv/tb_dram_bank_state_tracker.sv ====
// self-checking bench: both ends joined, plus one device end driven directly
`timescale 1ns/1ps
module tb_dram_bank_state_tracker;
  import lpx_pkg::*;
  typedef struct {lpx_cmd_e c; int b; logic ap; lpx_bank_e mid; int n; lpx_bank_e fin;} lpx_row_s;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic reqValid = 1'b0;
  logic reqAp = 1'b0;
  logic lowPower = 1'b0;
  lpx_cmd_e reqCmd = CMD_NOP;
  logic [BANK_W-1:0] reqBank = 3'h0;
  logic reqReady, illegalCmd, deviceReady, ill2, rdy2;
  int mismatches = 0;
  int samplesChecked = 0;
  lpx_row_s rows [15] = '{
    '{CMD_RST, 0, 1'b0, ST_RESETTING, int'(INIT_CYC), ST_IDLE},
    '{CMD_MRW, 0, 1'b0, ST_MRWRITING, int'(MRW_CYC), ST_IDLE},
    '{CMD_MRR, 0, 1'b0, ST_MRR_IDLE, int'(MRR_CYC), ST_IDLE},
    '{CMD_REFAB, 7, 1'b0, ST_REFRESHING, int'(RFCAB_CYC), ST_IDLE},
    '{CMD_REFPB, 3, 1'b0, ST_REFRESHING, int'(RFCPB_CYC), ST_IDLE},
    '{CMD_PRE, 2, 1'b0, ST_PRECHARGING, int'(RP_CYC), ST_IDLE},
    '{CMD_ACT, 1, 1'b0, ST_ACTIVATING, int'(RCD_CYC), ST_ACTIVE},
    '{CMD_RD, 1, 1'b0, ST_READING, int'(BURST_CYC), ST_ACTIVE},
    '{CMD_WR, 1, 1'b0, ST_WRITING, int'(BURST_CYC), ST_ACTIVE},
    '{CMD_MRR, 1, 1'b0, ST_MRR_ACT, int'(MRR_CYC), ST_ACTIVE},
    '{CMD_PRE, 1, 1'b0, ST_PRECHARGING, int'(RP_CYC), ST_IDLE},
    '{CMD_ACT, 4, 1'b0, ST_ACTIVATING, int'(RCD_CYC), ST_ACTIVE},
    '{CMD_RD, 4, 1'b1, ST_RD_AP, int'(BURST_CYC + RP_CYC), ST_IDLE},
    '{CMD_ACT, 6, 1'b0, ST_ACTIVATING, int'(RCD_CYC), ST_ACTIVE},
    '{CMD_PREA, 6, 1'b0, ST_PREALL, int'(RP_CYC), ST_IDLE}};

  // ****
  // ends, link and checker
  // ****
  lpx_cmd_if lnk();
  lpx_cmd_if lnk2();
  lpx_dram_ctl u_lpx_dram_ctl(.ref_clk(ref_clk), .reset_n(reset_n), .link(lnk),
    .reqValid(reqValid), .reqCmd(reqCmd), .reqBank(reqBank), .reqAp(reqAp),
    .reqReady(reqReady), .lowPower(lowPower));
  lpx_dram_bank_dev u_lpx_dram_bank_dev(.ref_clk(ref_clk), .reset_n(reset_n), .link(lnk),
    .illegalCmd(illegalCmd), .deviceReady(deviceReady));
  // second device end faces the bench so rule-breaking commands can reach it
  lpx_dram_bank_dev u_lpx_dram_bank_dev_b(.ref_clk(ref_clk), .reset_n(reset_n), .link(lnk2),
    .illegalCmd(ill2), .deviceReady(rdy2));
  lpx_link_chk u_lpx_link_chk(.ref_clk(ref_clk), .reset_n(reset_n), .cke(lnk.cke),
    .cmd(lnk.cmd), .bank(lnk.bank), .autoPre(lnk.autoPre), .bankState(lnk.bankState));

  // ****
  // tasks
  // ****
  task automatic check_state(input string nm, input lpx_bank_e e, input lpx_bank_e g);
    samplesChecked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_bit(input string nm, input logic e, input logic g);
    samplesChecked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  // returns one edge after acceptance, the edge where the device takes the command
  task automatic issue(input lpx_cmd_e c, input int b, input logic ap);
    int w;
    @(posedge ref_clk);
    reqValid <= 1'b1;
    reqCmd <= c;
    reqBank <= BANK_W'(b);
    reqAp <= ap;
    w = 0;
    do begin
      @(negedge ref_clk);
      w++;
    end while (reqReady !== 1'b1 && w < 200);
    check_bit("request ready", 1'b1, reqReady);
    @(posedge ref_clk);
    reqValid <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic drv2(input lpx_cmd_e c, input logic k);
    @(posedge ref_clk);
    lnk2.cke <= k;
    lnk2.cmd <= c;
    @(posedge ref_clk);
    lnk2.cmd <= CMD_NOP;
    @(negedge ref_clk);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****
  // clock, watchdog, sequence
  // ****
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    complete_run;
  end

  initial begin
    lnk2.cke = 1'b1;
    lnk2.cmd = CMD_NOP;
    lnk2.bank = 3'h0;
    lnk2.autoPre = 1'b0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    foreach (rows[k]) begin
      issue(rows[k].c, rows[k].b, rows[k].ap);
      @(negedge ref_clk);
      check_state($sformatf("row %0d entry", k), rows[k].mid, lnk.bankState[rows[k].b]);
      check_bit("row legal", 1'b0, illegalCmd);
      repeat (rows[k].n - 1) @(negedge ref_clk);
      check_state($sformatf("row %0d hold", k), rows[k].mid, lnk.bankState[rows[k].b]);
      @(negedge ref_clk);
      check_state($sformatf("row %0d exit", k), rows[k].fin, lnk.bankState[rows[k].b]);
    end
    check_bit("device ready", 1'b1, deviceReady);
    // power-down: enable drops, then first command waits out the exit time
    @(posedge ref_clk);
    lowPower <= 1'b1;
    repeat (20) @(negedge ref_clk);
    check_bit("clock enable", 1'b0, lnk.cke);
    @(posedge ref_clk);
    lowPower <= 1'b0;
    issue(CMD_ACT, 1, 1'b0);
    repeat (3) @(negedge ref_clk);
    check_state("bank1 open", ST_ACTIVE, lnk.bankState[1]);
    issue(CMD_WR, 1, 1'b1);
    @(posedge ref_clk);
    reqCmd <= CMD_RD;
    reqAp <= 1'b0;
    reqValid <= 1'b1;
    @(negedge ref_clk);
    check_bit("same bank ready", 1'b0, reqReady);
    issue(CMD_ACT, 2, 1'b0);
    @(negedge ref_clk);
    check_state("bank2 beside burst", ST_ACTIVATING, lnk.bankState[2]);
    check_state("bank1 burst", ST_WR_AP, lnk.bankState[1]);
    // faults on the directly driven device, then a reset with a mode read inside it
    drv2(CMD_ACT, 1'b1);
    check_bit("illegal pulse", 1'b1, ill2);
    check_state("dev2 kept", ST_POWER_ON, lnk2.bankState[0]);
    @(negedge ref_clk);
    check_bit("illegal one cycle", 1'b0, ill2);
    drv2(CMD_RST, 1'b0);
    check_state("enable low ignored", ST_POWER_ON, lnk2.bankState[0]);
    drv2(CMD_RST, 1'b1);
    check_state("enable rise ignored", ST_POWER_ON, lnk2.bankState[0]);
    // enable high on two edges, but the exit counter has not run out yet
    drv2(CMD_NOP, 1'b0);
    @(posedge ref_clk);
    lnk2.cke <= 1'b1;
    @(posedge ref_clk);
    lnk2.cmd <= CMD_RST;
    @(posedge ref_clk);
    lnk2.cmd <= CMD_NOP;
    @(negedge ref_clk);
    check_state("exit time ignored", ST_POWER_ON, lnk2.bankState[0]);
    repeat (3) @(negedge ref_clk);
    drv2(CMD_RST, 1'b1);
    check_state("dev2 resetting", ST_RESETTING, lnk2.bankState[5]);
    check_bit("dev2 not ready", 1'b0, rdy2);
    drv2(CMD_MRR, 1'b1);
    check_state("dev2 mode read", ST_MRR_RST, lnk2.bankState[5]);
    @(negedge ref_clk);
    check_state("dev2 back resetting", ST_RESETTING, lnk2.bankState[5]);
    // second reset in mid-run
    @(posedge ref_clk);
    reset_n <= 1'b0;
    @(negedge ref_clk);
    for (int k = 0; k < NUM_BANKS; k++) begin
      check_state("reset state", BANK_RST, lnk.bankState[k]);
    end
    check_bit("reset ready", 1'b0, deviceReady);
    check_bit("reset illegal", 1'b0, illegalCmd);
    check_bit("reset enable", 1'b1, lnk.cke);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(negedge ref_clk);
    check_state("after reset", BANK_RST, lnk.bankState[0]);
    complete_run;
  end
endmodule
